/* File: hw/byte_queue.sv */
// Purpose: synchronous queue with valid/ready on both sides
// Assumes: single clock, flush empties the queue at once
// Notes:   depth must be a power of two
`timescale 1ns/1ps
`default_nettype none
module byte_queue
    import uart_regs_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
)(
    // Clock and reset
    input  wire logic             mclk,
    input  wire logic             rst,
    input  wire logic             flush,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_reg;
    logic [AW-1:0]    rd_ptr_reg;
    logic [AW:0]      count_reg;
    logic             push;
    logic             pop;

    // Full compares the count at its own width, one bit wider than a pointer
    assign in_ready  = (count_reg != (AW+1)'(DEPTH)) && !flush;
    assign out_valid = (count_reg != '0);
    assign out_data  = mem[rd_ptr_reg];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready && !flush;

    // Storage is not reset, only the pointers and the count are
    always_ff @(posedge mclk)
    begin
        if (push)
            mem[wr_ptr_reg] <= in_data;
    end

    // Pointers and count
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end
        else if (flush)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end
        else
        begin
            if (push)
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            if (pop)
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule
`default_nettype wire

/* File: hw/uart_register_map_decoder.sv */
// Purpose: host register map of a queued serial port, three pages
// Assumes: bus pins are asynchronous to mclk and are synchronised
// Notes:   an access takes effect a few mclk cycles after its strobe
`timescale 1ns/1ps
`default_nettype none
module uart_register_map_decoder
    import uart_regs_pkg::*;
#(
    parameter logic [7:0] REVISION_CODE = 8'h01, // Arbitrary value
    parameter logic [7:0] CHIP_IDENT    = 8'hA5  // Arbitrary value
)(
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst,
    // Host bus pins
    input  wire logic        cs_n,
    input  wire logic        rd_n,
    input  wire logic        wr_n,
    input  wire logic [2:0]  addr,
    input  wire logic [7:0]  data_in,
    output logic      [7:0]  data_out,
    output logic             data_oe,
    // Core receive stream
    input  wire logic        rx_valid,
    output logic             rx_ready,
    input  wire logic [7:0]  rx_data,
    // Core transmit stream
    output logic             tx_valid,
    input  wire logic        tx_ready,
    output logic      [7:0]  tx_data,
    // Core configuration and status
    output var core_cfg_t    cfg,
    input  wire core_stat_t  stat
);
    // ==================================================================
    // Bus synchroniser and strobe detection
    logic [13:0] s1_reg;
    logic [13:0] s2_reg;
    logic        rd_act_d_reg;
    logic        wr_act_d_reg;
    logic [2:0]  bus_addr_reg;
    logic [7:0]  wr_data_reg;
    logic        rd_act;
    logic        wr_act;
    logic        rd_start;
    logic        rd_end;
    logic        wr_pulse;

    // Two flops before any logic reads the pins
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            s1_reg <= 14'h3FFF;
            s2_reg <= 14'h3FFF;
        end
        else
        begin
            s1_reg <= {cs_n, rd_n, wr_n, addr, data_in};
            s2_reg <= s1_reg;
        end
    end

    assign rd_act   = !s2_reg[13] && !s2_reg[12];
    assign wr_act   = !s2_reg[13] && !s2_reg[11];
    assign rd_start = rd_act && !rd_act_d_reg;
    assign rd_end   = !rd_act && rd_act_d_reg;
    assign wr_pulse = !wr_act && wr_act_d_reg;

    // Address and write data held from the active phase
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            rd_act_d_reg <= 1'b0;
            wr_act_d_reg <= 1'b0;
            bus_addr_reg <= 3'h0;
            wr_data_reg  <= REG_RST;
        end
        else
        begin
            rd_act_d_reg <= rd_act;
            wr_act_d_reg <= wr_act;
            if (rd_act || wr_act)
                bus_addr_reg <= s2_reg[10:8];
            if (wr_act)
                wr_data_reg <= s2_reg[7:0];
        end
    end

    // ==================================================================
    // Page decode
    logic [7:0] lcr_reg, dll_reg, dlm_reg, ier_reg, fcr_reg, mcr_reg;
    logic [7:0] efr_reg, xfr_reg, ir_pulse_width_reg, spr_reg;
    logic [7:0] resume_char_one_reg, resume_char_two_reg, pause_char_one_reg, pause_char_two_reg;
    logic       enh_page, div_page, std_page, enh_en, div_zero;
    logic [2:0] acc_addr;

    assign acc_addr = rd_start ? s2_reg[10:8] : bus_addr_reg;
    assign enh_page = (lcr_reg == ENH_KEY);
    assign div_page = lcr_reg[LCR_DIV_BIT] && !enh_page;
    assign std_page = !lcr_reg[LCR_DIV_BIT];
    assign enh_en   = efr_reg[EFR_EN_BIT];
    assign div_zero = (dll_reg == 8'h00) && (dlm_reg == 8'h00);

    // Gated fields read as zero and act as zero while locked
    function automatic logic [7:0] gate(input logic [7:0] v,
                                        input logic [7:0] m,
                                        input logic       en);
        gate = en ? v : (v & ~m);
    endfunction

    function automatic logic hit(input logic [2:0] a,
                                 input logic [2:0] ofs);
        hit = (a == ofs);
    endfunction

    // ==================================================================
    // Write decode, one process per register group
    logic wr_std, wr_div, wr_enh;
    assign wr_std = wr_pulse && std_page;
    assign wr_div = wr_pulse && div_page;
    assign wr_enh = wr_pulse && enh_page;

    // Line control is reachable on every page
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            lcr_reg <= REG_RST;
        else if (wr_pulse && hit(bus_addr_reg, OFS_LINE))
            lcr_reg <= wr_data_reg;
    end

    // Divisor bytes on the divisor page only
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            dll_reg <= REG_RST;
            dlm_reg <= REG_RST;
        end
        else if (wr_div)
        begin
            if (hit(bus_addr_reg, OFS_DATA))
                dll_reg <= wr_data_reg;
            if (hit(bus_addr_reg, OFS_IEN))
                dlm_reg <= wr_data_reg;
        end
    end

    // Standard page controls; locked bits are stored as zero
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            ier_reg <= REG_RST;
            fcr_reg <= REG_RST;
            mcr_reg <= REG_RST;
            spr_reg <= REG_RST;
        end
        else if (wr_std)
        begin
            if (hit(bus_addr_reg, OFS_IEN))
                ier_reg <= gate(wr_data_reg, IER_GATE, enh_en);
            if (hit(bus_addr_reg, OFS_QUEUE))
                fcr_reg <= gate(wr_data_reg, FCR_GATE, enh_en);
            if (hit(bus_addr_reg, OFS_MODEM))
                mcr_reg <= gate(wr_data_reg, MCR_GATE, enh_en);
            if (hit(bus_addr_reg, OFS_SCR))
                spr_reg <= wr_data_reg;
        end
    end

    // Extra feature and pulse width behind the enhanced enable
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            xfr_reg  <= REG_RST;
            ir_pulse_width_reg <= REG_RST;
        end
        else if (wr_std && enh_en)
        begin
            if (hit(bus_addr_reg, OFS_LSTAT))
                xfr_reg <= wr_data_reg & XFR_KEEP;
            if (hit(bus_addr_reg, OFS_MSTAT))
                ir_pulse_width_reg <= wr_data_reg;
        end
    end

    // Enhanced page; host must select it with the key value first
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            efr_reg   <= REG_RST;
            resume_char_one_reg  <= REG_RST;
            resume_char_two_reg  <= REG_RST;
            pause_char_one_reg <= REG_RST;
            pause_char_two_reg <= REG_RST;
        end
        else if (wr_enh)
        begin
            unique case (bus_addr_reg)
                OFS_QUEUE: efr_reg   <= wr_data_reg;
                OFS_MODEM: resume_char_one_reg  <= wr_data_reg;
                OFS_LSTAT: resume_char_two_reg  <= wr_data_reg;
                OFS_MSTAT: pause_char_one_reg <= wr_data_reg;
                OFS_SCR:   pause_char_two_reg <= wr_data_reg;
                default:   efr_reg   <= efr_reg;
            endcase
        end
    end

    // ==================================================================
    // Queues in the data path
    logic       tx_in_ready, rx_out_valid, tx_push, rx_pop;
    logic       rx_flush, tx_flush;
    logic [7:0] rx_head;

    // Reset bits in queue control act once, on the write itself
    assign rx_flush = wr_std && hit(bus_addr_reg, OFS_QUEUE)
                      && wr_data_reg[FCR_RXR_BIT];
    assign tx_flush = wr_std && hit(bus_addr_reg, OFS_QUEUE)
                      && wr_data_reg[FCR_TXR_BIT];
    // A byte written to a full queue is dropped, not stalled
    assign tx_push  = wr_std && hit(bus_addr_reg, OFS_DATA);
    // Pop at the end of the read so the host saw the old head
    assign rx_pop   = rd_end && std_page
                      && hit(bus_addr_reg, OFS_DATA);

    byte_queue #(.WIDTH(QWIDTH), .DEPTH(QDEPTH)) tx_queue (
        .mclk      (mclk),
        .rst       (rst),
        .flush     (tx_flush),
        .in_valid  (tx_push),
        .in_ready  (tx_in_ready),
        .in_data   (wr_data_reg),
        .out_valid (tx_valid),
        .out_ready (tx_ready),
        .out_data  (tx_data)
    );

    byte_queue #(.WIDTH(QWIDTH), .DEPTH(QDEPTH)) rx_queue (
        .mclk      (mclk),
        .rst       (rst),
        .flush     (rx_flush),
        .in_valid  (rx_valid),
        .in_ready  (rx_ready),
        .in_data   (rx_data),
        .out_valid (rx_out_valid),
        .out_ready (rx_pop),
        .out_data  (rx_head)
    );

    // ==================================================================
    // Read mux
    logic [7:0] isr_val, lsr_val, msr_val, rd_mux;
    logic [7:0] rd_data_reg;

    assign isr_val = {{2{fcr_reg[FCR_EN_BIT]}},
                      enh_en ? stat.irq_code[5:4] : 2'b00,
                      stat.irq_code[3:0]};
    assign lsr_val = {stat.rx_queue_err,
                      !tx_valid && stat.tsr_empty,
                      !tx_valid, stat.line_err,
                      rx_out_valid};
    assign msr_val = stat.modem_status;

    always_comb
    begin
        rd_mux = 8'h00;
        if (enh_page)
        begin
            unique case (acc_addr)
                OFS_QUEUE: rd_mux = efr_reg;
                OFS_LINE:  rd_mux = lcr_reg;
                OFS_MODEM: rd_mux = resume_char_one_reg;
                OFS_LSTAT: rd_mux = resume_char_two_reg;
                OFS_MSTAT: rd_mux = pause_char_one_reg;
                OFS_SCR:   rd_mux = pause_char_two_reg;
                default:   rd_mux = 8'h00;
            endcase
        end
        else if (div_page)
        begin
            unique case (acc_addr)
                OFS_DATA:  rd_mux = div_zero ? REVISION_CODE
                                             : dll_reg;
                OFS_IEN:   rd_mux = div_zero ? CHIP_IDENT
                                             : dlm_reg;
                OFS_LINE:  rd_mux = lcr_reg;
                default:   rd_mux = 8'h00;
            endcase
        end
        else
        begin
            unique case (acc_addr)
                OFS_DATA:  rd_mux = rx_head;
                OFS_IEN:   rd_mux = gate(ier_reg, IER_GATE, enh_en);
                OFS_QUEUE: rd_mux = isr_val;
                OFS_LINE:  rd_mux = lcr_reg;
                OFS_MODEM: rd_mux = gate(mcr_reg, MCR_GATE, enh_en);
                OFS_LSTAT: rd_mux = lsr_val;
                OFS_MSTAT: rd_mux = msr_val;
                OFS_SCR:   rd_mux = spr_reg;
            endcase
        end
    end

    // Read data is frozen at the start of the read strobe
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            rd_data_reg <= 8'h00;
        else if (rd_start)
            rd_data_reg <= rd_mux;
    end

    assign data_out = rd_data_reg;
    assign data_oe  = rd_act_d_reg;

    // ==================================================================
    // Configuration to the core, locked fields forced to zero
    assign cfg = '{line_control:      lcr_reg,
                   baud_divisor_high: dlm_reg,
                   baud_divisor_low:  dll_reg,
                   irq_enable:        gate(ier_reg, IER_GATE, enh_en),
                   queue_control:     gate(fcr_reg, FCR_GATE, enh_en),
                   modem_control:     gate(mcr_reg, MCR_GATE, enh_en),
                   extra_feature:     enh_en ? xfr_reg : 8'h00,
                   ir_pulse_width:    enh_en ? ir_pulse_width_reg : 8'h00,
                   enhanced_function: efr_reg,
                   resume_char_one:   resume_char_one_reg,
                   resume_char_two:   resume_char_two_reg,
                   pause_char_one:    pause_char_one_reg,
                   pause_char_two:    pause_char_two_reg};

    // ==================================================================
    // Assertions
    property p_rx_pop;
        @(posedge mclk) disable iff (rst)
        rx_pop && rx_out_valid && !rx_flush |=> !rx_pop;
    endproperty
    a_rx_pop: assert property (p_rx_pop) else $error("rx pop repeated");

    property p_lcr_wr;
        @(posedge mclk) disable iff (rst)
        wr_pulse && bus_addr_reg == OFS_LINE |=> lcr_reg == $past(wr_data_reg);
    endproperty
    a_lcr_wr: assert property (p_lcr_wr) else $error("line control lost");

    property p_ier_lock;
        @(posedge mclk) disable iff (rst)
        rd_start && std_page && !enh_en && acc_addr == OFS_IEN
        |=> rd_data_reg[7:4] == 4'h0;
    endproperty
    a_ier_lock: assert property (p_ier_lock) else $error("ier lock");

    property p_isr_q;
        @(posedge mclk) disable iff (rst)
        rd_start && std_page && acc_addr == OFS_QUEUE
        |=> rd_data_reg[7:6] == {2{fcr_reg[FCR_EN_BIT]}};
    endproperty
    a_isr_q: assert property (p_isr_q) else $error("isr queue bits");

    property p_dll_wr;
        @(posedge mclk) disable iff (rst)
        wr_div && bus_addr_reg == OFS_DATA |=> dll_reg == $past(wr_data_reg);
    endproperty
    a_dll_wr: assert property (p_dll_wr) else $error("divisor low");

    property p_ident;
        @(posedge mclk) disable iff (rst)
        rd_start && div_page && div_zero && acc_addr == OFS_IEN
        |=> rd_data_reg == CHIP_IDENT ##1 data_oe;
    endproperty
    a_ident: assert property (p_ident) else $error("ident read");

    property p_efr_wr;
        @(posedge mclk) disable iff (rst)
        wr_enh && bus_addr_reg == OFS_QUEUE |=> efr_reg == $past(wr_data_reg);
    endproperty
    a_efr_wr: assert property (p_efr_wr) else $error("efr write");

    property p_xfr_ro;
        @(posedge mclk) disable iff (rst)
        wr_std && !enh_en && bus_addr_reg == OFS_LSTAT |=> $stable(xfr_reg);
    endproperty
    a_xfr_ro: assert property (p_xfr_ro) else $error("xfr unlocked");

    property p_xfr_rsv;
        @(posedge mclk) disable iff (rst)
        xfr_reg[7:6] == 2'b00;
    endproperty
    a_xfr_rsv: assert property (p_xfr_rsv) else $error("xfr reserved");

    c_tx_push: cover property (@(posedge mclk) tx_push && tx_in_ready);
    c_rx_read: cover property (@(posedge mclk) rx_pop && rx_out_valid);
    c_enh_wr:  cover property (@(posedge mclk) wr_enh);
endmodule
`default_nettype wire

/* File: hw/uart_regs_pkg.sv */
// Purpose: constants and carriers for the serial port register map decoder
// Assumes: 8-bit host bus with three address lines, one device clock
// Notes:   reset values are all zero; identity codes are top parameters
package uart_regs_pkg;

    // ==================================================================
    // Register offsets
    localparam logic [2:0] OFS_DATA   = 3'h0;
    localparam logic [2:0] OFS_IEN    = 3'h1;
    localparam logic [2:0] OFS_QUEUE  = 3'h2;
    localparam logic [2:0] OFS_LINE   = 3'h3;
    localparam logic [2:0] OFS_MODEM  = 3'h4;
    localparam logic [2:0] OFS_LSTAT  = 3'h5;
    localparam logic [2:0] OFS_MSTAT  = 3'h6;
    localparam logic [2:0] OFS_SCR    = 3'h7;

    // ==================================================================
    // Field positions, page key and reset values
    localparam int         LCR_DIV_BIT  = 7;
    localparam int         EFR_EN_BIT   = 4;
    localparam int         FCR_EN_BIT   = 0;
    localparam int         FCR_RXR_BIT  = 1;
    localparam int         FCR_TXR_BIT  = 2;
    localparam logic [7:0] ENH_KEY      = 8'hBF;
    localparam logic [7:0] IER_GATE     = 8'hF0;
    localparam logic [7:0] FCR_GATE     = 8'h30;
    localparam logic [7:0] MCR_GATE     = 8'hE0;
    localparam logic [7:0] XFR_KEEP     = 8'h3F;
    localparam logic [7:0] REG_RST      = 8'h00;
    localparam int         QDEPTH       = 16;
    localparam int         QWIDTH       = 8;

    // Configuration handed to the serial core, already gated
    typedef struct packed {
        logic [7:0] line_control;
        logic [7:0] baud_divisor_high;
        logic [7:0] baud_divisor_low;
        logic [7:0] irq_enable;
        logic [7:0] queue_control;
        logic [7:0] modem_control;
        logic [7:0] extra_feature;
        logic [7:0] ir_pulse_width;
        logic [7:0] enhanced_function;
        logic [7:0] resume_char_one;
        logic [7:0] resume_char_two;
        logic [7:0] pause_char_one;
        logic [7:0] pause_char_two;
    } core_cfg_t;

    // Status reported by the serial core
    typedef struct packed {
        logic [5:0] irq_code;
        logic [3:0] line_err;
        logic       rx_queue_err;
        logic       tsr_empty;
        logic [7:0] modem_status;
    } core_stat_t;

endpackage

/* File: testbench/host_bus_model.sv */
// Purpose: host processor model driving the 8-bit register bus
// Assumes: write strobes low for 5 mclk, read strobes 4, idle at least 7 mclk between cycles
// Notes:   write data released shows the inverse of the last byte
`timescale 1ns/1ps
`default_nettype none
module host_bus_model (
    // Clock
    input  wire logic       mclk,
    // Bus pins
    output logic            cs_n,
    output logic            rd_n,
    output logic            wr_n,
    output logic [2:0]      addr,
    output logic [7:0]      data_in,
    input  wire logic [7:0] data_out,
    input  wire logic       data_oe
);
    // ==================================================================
    // Bus cycles
    initial
    begin
        {cs_n, rd_n, wr_n} = 3'h7;
        addr = 3'h0;
        data_in = 8'h00;
    end

    // Data held 3 cycles past the strobe so the synced latch sees it
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge mclk);
        {cs_n, wr_n} <= 2'h0;
        addr <= a;
        data_in <= d;
        repeat (5) @(posedge mclk);
        {cs_n, wr_n} <= 2'h3;
        repeat (3) @(posedge mclk);
        data_in <= ~d;
        repeat (4) @(posedge mclk);
    endtask

    // Waits for the drive enable under a bound, then releases
    task automatic rd(input logic [2:0] a, output logic [7:0] d,
                      output bit ok);
        int n;
        @(posedge mclk);
        {cs_n, rd_n} <= 2'h0;
        addr <= a;
        n = 0;
        do
        begin
            @(posedge mclk);
            #1;
            n++;
        end
        while (data_oe !== 1'b1 && n < 12);
        ok = (data_oe === 1'b1);
        d = data_out;
        @(posedge mclk);
        {cs_n, rd_n} <= 2'h3;
        repeat (6) @(posedge mclk);
    endtask
endmodule
`default_nettype wire

/* File: testbench/test_uart_register_map_decoder.sv */
// Purpose: self-checking bench for the serial port register map
// Assumes: host model on the bus, bench drives core streams and status
// Notes:   identity values below are arbitrary
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin \
    bad_count++; $display("BAD %0t got %h want %h", $time, (a), (e)); \
    end end
module test_uart_register_map_decoder;
    import uart_regs_pkg::*;
    localparam logic [7:0] REV_VAL = 8'h3C; // Arbitrary value
    localparam logic [7:0] ID_VAL  = 8'h5E; // Arbitrary value
    logic       mclk, rst, cs_n, rd_n, wr_n, data_oe;
    logic       rx_valid, rx_ready, tx_valid, tx_ready;
    logic [2:0] addr;
    logic [7:0] data_in, data_out, rx_data, tx_data;
    core_cfg_t  cfg;
    core_stat_t stat;
    int         bad_count, comparisons;

    // ==================================================================
    // Instances and clock
    uart_register_map_decoder #(.REVISION_CODE(REV_VAL), .CHIP_IDENT(ID_VAL))
    u_uart_register_map_decoder (.mclk(mclk), .rst(rst), .cs_n(cs_n),
        .rd_n(rd_n), .wr_n(wr_n), .addr(addr), .data_in(data_in),
        .data_out(data_out), .data_oe(data_oe), .rx_valid(rx_valid),
        .rx_ready(rx_ready), .rx_data(rx_data), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .tx_data(tx_data), .cfg(cfg), .stat(stat));
    host_bus_model u_host_bus_model (.mclk(mclk), .cs_n(cs_n), .rd_n(rd_n),
        .wr_n(wr_n), .addr(addr), .data_in(data_in), .data_out(data_out),
        .data_oe(data_oe));
    initial
    begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    // ==================================================================
    // Shared tasks
    task automatic conclude;
        $display("Mismatches %0d, comparisons %0d", bad_count, comparisons);
        if (bad_count == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        u_host_bus_model.wr(a, d);
    endtask
    // A read that never drives the bus ends the run
    task automatic rc(input logic [2:0] a, input logic [7:0] e);
        logic [7:0] d;
        bit         ok;
        u_host_bus_model.rd(a, d, ok);
        if (!ok)
        begin
            bad_count++;
            conclude();
        end
        `CHK(d, e)
    endtask

    // ==================================================================
    // Scenarios
    task automatic check_pages;
        wr(3'h7, 8'h5A);
        rc(3'h7, 8'h5A);
        wr(3'h3, 8'h80);
        rc(3'h0, REV_VAL);
        rc(3'h1, ID_VAL);
        wr(3'h0, 8'h12);
        wr(3'h1, 8'h34);
        rc(3'h0, 8'h12);
        rc(3'h1, 8'h34);
        wr(3'h3, 8'h03);
        rc(3'h3, 8'h03);
        `CHK(cfg.line_control, 8'h03)
        wr(3'h1, 8'hFF);
        rc(3'h1, 8'h0F);
        wr(3'h4, 8'hFF);
        `CHK(cfg.modem_control, 8'h1F)
    endtask
    task automatic check_enhanced;
        wr(3'h3, 8'hBF);
        wr(3'h2, 8'h10);
        rc(3'h2, 8'h10);
        for (int k = 4; k < 8; k++)
            wr(3'(k), 8'(8'h70 + k));
        for (int k = 4; k < 8; k++)
            rc(3'(k), 8'(8'h70 + k));
        wr(3'h0, 8'h99);
        `CHK(cfg.baud_divisor_low, 8'h12)
        wr(3'h3, 8'h00);
        wr(3'h1, 8'hFF);
        rc(3'h1, 8'hFF);
        wr(3'h5, 8'hFF);
        `CHK(cfg.extra_feature, 8'h3F)
        wr(3'h6, 8'h77);
        `CHK(cfg.ir_pulse_width, 8'h77)
        wr(3'h2, 8'h31);
        `CHK(cfg.queue_control, 8'h31)
        @(posedge mclk);
        stat.irq_code <= 6'h26;
        stat.modem_status <= 8'hA5;
        stat.tsr_empty <= 1'b1;
        rc(3'h2, 8'hE6);
        rc(3'h6, 8'hA5);
    endtask
    // Fill the receive queue until refused, then drain in order
    task automatic check_rx_queue;
        for (int i = 0; i < 16; i++)
        begin
            @(posedge mclk);
            rx_valid <= 1'b1;
            rx_data <= 8'(8'h40 + i);
            #1 `CHK(rx_ready, 1'b1)
        end
        @(posedge mclk);
        rx_valid <= 1'b0;
        #1 `CHK(rx_ready, 1'b0)
        rc(3'h5, 8'h61);
        for (int i = 0; i < 16; i++)
            rc(3'h0, 8'(8'h40 + i));
        rc(3'h5, 8'h60);
    endtask
    // Core stalls, so both bytes wait in the transmit queue
    task automatic check_tx_queue;
        wr(3'h0, 8'hC3);
        wr(3'h0, 8'h3C);
        `CHK(tx_valid, 1'b1)
        `CHK(tx_data, 8'hC3)
        rc(3'h5, 8'h00);
        @(posedge mclk);
        tx_ready <= 1'b1;
        @(posedge mclk);
        #1 `CHK(tx_data, 8'h3C)
        @(posedge mclk);
        tx_ready <= 1'b0;
        #1 `CHK(tx_valid, 1'b0)
    endtask

    // ==================================================================
    // Main sequence
    initial
    begin
        bad_count = 0;
        comparisons = 0;
        rst = 1'b1;
        {rx_valid, tx_ready} = 2'h0;
        rx_data = 8'h00;
        stat = '0;
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        check_pages();
        check_enhanced();
        check_rx_queue();
        check_tx_queue();
        conclude();
    end
endmodule
`default_nettype wire
